// ==== mae_defs.svh ====
// Constants for the dual multiply-accumulate and extract datapath:
// register offsets, field positions, reset values and saturation limits.
// Assumes it is included by bare name from the package and the datapath.
`ifndef MAE_DEFS_SVH
`define MAE_DEFS_SVH

// Register byte offsets on the APB bus
`define MAE_OFF_CTRL     8'h00
`define MAE_OFF_OPS0     8'h04
`define MAE_OFF_OPS1     8'h08
`define MAE_OFF_STAT     8'h0c
`define MAE_OFF_ACC0_LO  8'h10
`define MAE_OFF_ACC0_HI  8'h14
`define MAE_OFF_ACC1_LO  8'h18
`define MAE_OFF_ACC1_HI  8'h1c
`define MAE_OFF_DREG     8'h20
`define MAE_OFF_END      8'h40

// Status register bit positions
`define MAE_ST_UNBIASED  0
`define MAE_ST_V         1
`define MAE_ST_VS        2
`define MAE_ST_AV0       3
`define MAE_ST_AV0S      4
`define MAE_ST_AV1       5
`define MAE_ST_SECOND_ACCUM_OVERFLOW_STICKY      6
`define MAE_ST_BUSY      8

// Reset values
`define MAE_RST_CTRL     12'h000
`define MAE_RST_WORD     32'h0000_0000
`define MAE_RST_ACC      40'h00_0000_0000

// Saturation limits, all at the 42-bit working width except the 16-bit MAE_FRAC_MIN16
`define MAE_SAT40_MAX    42'sh007f_ffff_ffff
`define MAE_SAT40_MIN    42'sh380_0000_0000
`define MAE_USAT40_MAX   42'sh00ff_ffff_ffff
`define MAE_SAT32_MAX    42'sh0000_7fff_ffff
`define MAE_SAT32_MIN    42'sh3ff_8000_0000
`define MAE_USAT32_MAX   42'sh0000_ffff_ffff
`define MAE_SAT16_MAX    42'sh0000_0000_7fff
`define MAE_SAT16_MIN    42'sh3ff_ffff_8000
`define MAE_USAT16_MAX   42'sh0000_0000_ffff
`define MAE_ZERO42       42'sh0
`define MAE_RND_HALF     42'sh0000_0000_8000
`define MAE_FRAC_MIN16   16'h8000
`define MAE_FRAC_CAP     42'sh0000_7fff_ffff

`endif

// ==== mae_pkg.sv ====
// Types shared by the datapath and the bench: command word, status
// bits, APB carriers and the datapath's state record.
// Assumes mae_defs.svh sits in the same folder.
`include "mae_defs.svh"

package mae_pkg;

    // Extraction and product options
    typedef enum logic [2:0] {
        opt_signed_frac  = 3'h0,
        opt_unsigned_frac = 3'h1,
        opt_signed_int   = 3'h2,
        opt_trunc_frac   = 3'h3,
        opt_trunc_ufrac  = 3'h4,
        opt_scaled_rnd   = 3'h5,
        opt_scaled_int   = 3'h6,
        opt_int_high     = 3'h7
    } mae_opt_e;

    // Accumulator operation; code 3 is treated as a load
    typedef enum logic [1:0] {
        acc_load = 2'h0,
        acc_add  = 2'h1,
        acc_sub  = 2'h2
    } mae_accop_e;

    // Command word, laid out as the control register
    typedef struct packed {
        logic [2:0] dest;
        logic       full;
        logic       mixed;
        logic [2:0] opt;
        logic [1:0] op;
        logic       run1;
        logic       run0;
    } mae_cmd_s;

    // Arithmetic status register bits
    typedef struct packed {
        logic second_accum_overflow_sticky;
        logic av1;
        logic av0s;
        logic av0;
        logic vs;
        logic v;
        logic unbiased;
    } mae_stat_s;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } mae_apb_req_s;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } mae_apb_rsp_s;

    // Outcome of one unit's multiply, accumulate and extract
    typedef struct packed {
        logic [39:0] acc;
        logic        acc_sat;
        logic [31:0] res;
        logic        res_sat;
    } mae_unit_s;

    // Whole datapath state
    typedef struct packed {
        logic [39:0]       acc0;
        logic [39:0]       acc1;
        logic [7:0][31:0]  dreg;
        mae_cmd_s          cmd;
        logic              pend;
        logic [31:0]       ops0;
        logic [31:0]       ops1;
        mae_stat_s         st;
        logic [31:0]       prdata;
    } mae_state_s;

endpackage

// ==== mae_mac_extract.sv ====
// Dual multiply-accumulate datapath with saturated extraction into a
// small data register file, reached as an APB slave.
// Assumes one clock domain with the APB master; operands and commands
// are written by the master, results read back from the register file.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "mae_defs.svh"

module mae_mac_extract (
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // APB slave
    input  wire mae_pkg::mae_apb_req_s apb_req,
    output      mae_pkg::mae_apb_rsp_s apb_rsp
);
    import mae_pkg::*;

    mae_state_s s_r;
    mae_state_s s_nxt;
    mae_unit_s  u0;
    mae_unit_s  u1;
    logic       acc_wr;
    logic       setup;
    logic       mapped;

    // Clamp a working value to [lo, hi]; flag tells whether it clipped
    function automatic logic [42:0] sat42(
        input logic signed [41:0] x,
        input logic signed [41:0] lo,
        input logic signed [41:0] hi
    );
        logic signed [41:0] y;
        logic               c;
        y = x;
        c = 1'b0;
        if (x > hi) begin
            y = hi;
            c = 1'b1;
        end else if (x < lo) begin
            y = lo;
            c = 1'b1;
        end
        return {c, y};
    endfunction

    // Add the round increment at bit 15; low bits are left to the caller.
    // Unbiased ties go to the even neighbour so averages do not drift.
    function automatic logic signed [41:0] rnd16(
        input logic signed [41:0] x,
        input logic               en,
        input logic               unbiased
    );
        logic signed [41:0] inc;
        inc = `MAE_ZERO42;
        if (en) begin
            if (unbiased && x[15:0] == 16'h8000 && !x[16])
                inc = `MAE_ZERO42;
            else
                inc = `MAE_RND_HALF;
        end
        return x + inc;
    endfunction

    // One unit: product, accumulator update, then extraction
    function automatic mae_unit_s mac_unit(
        input logic [39:0] acc,
        input logic [15:0] a,
        input logic [15:0] b,
        input mae_cmd_s    c,
        input logic        mixed,
        input logic        unbiased
    );
        mae_unit_s          r;
        logic               unsig;
        logic               sfrac;
        logic               dbl;
        logic               rnd_en;
        logic signed [41:0] sa;
        logic signed [41:0] sb;
        logic signed [41:0] ua;
        logic signed [41:0] ub;
        logic signed [41:0] p;
        logic signed [41:0] ax;
        logic signed [41:0] sum;
        logic signed [41:0] x;
        logic signed [41:0] rx;
        logic [42:0]        st;
        unsig  = (c.opt == opt_unsigned_frac) || (c.opt == opt_trunc_ufrac);
        sfrac  = (c.opt == opt_signed_frac) || (c.opt == opt_trunc_frac)
              || (c.opt == opt_scaled_rnd);
        dbl    = (c.opt == opt_scaled_rnd) || (c.opt == opt_scaled_int);
        rnd_en = (c.opt == opt_signed_frac) || (c.opt == opt_unsigned_frac)
              || (c.opt == opt_scaled_rnd) || (c.opt == opt_int_high);
        sa = {{26{a[15]}}, a};
        sb = {{26{b[15]}}, b};
        ua = {26'h0, a};
        ub = {26'h0, b};
        r  = '0;
        // Product; mixed sign and unsigned forms never shift
        if (mixed)
            p = sa * ub;
        else if (unsig)
            p = ua * ub;
        else if (sfrac && a == `MAE_FRAC_MIN16 && b == `MAE_FRAC_MIN16)
            p = `MAE_FRAC_CAP;
        else if (sfrac)
            p = (sa * sb) <<< 1;
        else
            p = sa * sb;
        // Extend the accumulator the same way as the product
        if (unsig)
            ax = {2'b00, acc};
        else
            ax = {{2{acc[39]}}, acc};
        unique case (c.op)
            acc_add: sum = ax + p;
            acc_sub: sum = ax - p;
            default: sum = p;
        endcase
        // Accumulator saturation per option
        if (unsig)
            st = sat42(sum, `MAE_ZERO42, `MAE_USAT40_MAX);
        else if (c.opt == opt_int_high)
            st = sat42(sum, `MAE_SAT32_MIN, `MAE_SAT32_MAX);
        else
            st = sat42(sum, `MAE_SAT40_MIN, `MAE_SAT40_MAX);
        r.acc     = st[39:0];
        r.acc_sat = st[42];
        // Extraction works on a copy; r.acc is already fixed
        x = st[41:0] <<< (dbl ? 1 : 0);
        if (c.full) begin
            // Full register: no option here rounds, bias is always biased
            if (unsig)
                st = sat42(x, `MAE_ZERO42, `MAE_USAT32_MAX);
            else
                st = sat42(x, `MAE_SAT32_MIN, `MAE_SAT32_MAX);
            r.res     = st[31:0];
            r.res_sat = st[42];
        end else if (c.opt == opt_int_high) begin
            rx = rnd16(x, 1'b1, unbiased);
            st = sat42(rx, `MAE_SAT32_MIN, `MAE_SAT32_MAX);
            r.res     = {16'h0, st[31:16]};
            r.res_sat = st[42];
        end else if (c.opt == opt_signed_int || c.opt == opt_scaled_int) begin
            st = sat42(x, `MAE_SAT16_MIN, `MAE_SAT16_MAX);
            r.res     = {16'h0, st[15:0]};
            r.res_sat = st[42];
        end else begin
            // Fraction extract: round or cut at bit 16, then clamp
            rx = rnd16(x, rnd_en, unbiased) >>> 16;
            if (unsig)
                st = sat42(rx, `MAE_ZERO42, `MAE_USAT16_MAX);
            else
                st = sat42(rx, `MAE_SAT16_MIN, `MAE_SAT16_MAX);
            r.res     = {16'h0, st[15:0]};
            r.res_sat = st[42];
        end
        return r;
    endfunction

    // Whether an address is mapped and word aligned, used by read and write decode
    function automatic logic mae_mapped(input logic [7:0] a);
        return (a < `MAE_OFF_END) && (a[1:0] == 2'b00);
    endfunction

    // Both units always evaluate; the command's run bits pick the effect.
    // Mixed sign is wired off for the first unit.
    assign u0 = mac_unit(s_r.acc0, s_r.ops0[15:0], s_r.ops0[31:16],
                         s_r.cmd, 1'b0, s_r.st.unbiased);
    assign u1 = mac_unit(s_r.acc1, s_r.ops1[15:0], s_r.ops1[31:16],
                         s_r.cmd, s_r.cmd.mixed, s_r.st.unbiased);

    // APB phase decode
    assign setup  = apb_req.psel && !apb_req.penable;
    assign acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign mapped = mae_mapped(apb_req.paddr);

    // Answer at once; unmapped or unaligned access is flagged as error
    always_comb begin
        apb_rsp.prdata  = s_r.prdata;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
    end

    // Next state: bus writes, read capture and command execution
    always_comb begin
        logic [31:0] w;
        logic        v_new;
        w     = apb_req.pwdata;
        v_new = 1'b0;
        s_nxt = s_r;
        s_nxt.pend = 1'b0;
        // Read data is latched in the setup phase so it comes from a flop
        if (setup) begin
            s_nxt.prdata = `MAE_RST_WORD;
            unique case (apb_req.paddr)
                `MAE_OFF_CTRL:    s_nxt.prdata = {20'h0, s_r.cmd};
                `MAE_OFF_OPS0:    s_nxt.prdata = s_r.ops0;
                `MAE_OFF_OPS1:    s_nxt.prdata = s_r.ops1;
                `MAE_OFF_STAT:    s_nxt.prdata = {23'h0, s_r.pend,
                                                  1'b0, s_r.st};
                `MAE_OFF_ACC0_LO: s_nxt.prdata = s_r.acc0[31:0];
                `MAE_OFF_ACC0_HI: s_nxt.prdata = {24'h0, s_r.acc0[39:32]};
                `MAE_OFF_ACC1_LO: s_nxt.prdata = s_r.acc1[31:0];
                `MAE_OFF_ACC1_HI: s_nxt.prdata = {24'h0, s_r.acc1[39:32]};
                default: begin
                    if (mapped && apb_req.paddr >= `MAE_OFF_DREG)
                        s_nxt.prdata = s_r.dreg[apb_req.paddr[4:2]];
                end
            endcase
        end
        // Writes take effect only in the access phase
        if (acc_wr && mapped) begin
            unique case (apb_req.paddr)
                `MAE_OFF_CTRL: begin
                    s_nxt.cmd  = mae_cmd_s'(w[11:0]);
                    s_nxt.pend = 1'b1;
                end
                `MAE_OFF_OPS0:    s_nxt.ops0 = w;
                `MAE_OFF_OPS1:    s_nxt.ops1 = w;
                `MAE_OFF_STAT: begin
                    // Stickies clear on a one; live flags are read only
                    s_nxt.st.unbiased = w[`MAE_ST_UNBIASED];
                    if (w[`MAE_ST_VS])
                        s_nxt.st.vs = 1'b0;
                    if (w[`MAE_ST_AV0S])
                        s_nxt.st.av0s = 1'b0;
                    if (w[`MAE_ST_SECOND_ACCUM_OVERFLOW_STICKY])
                        s_nxt.st.second_accum_overflow_sticky = 1'b0;
                end
                `MAE_OFF_ACC0_LO: s_nxt.acc0[31:0]  = w;
                `MAE_OFF_ACC0_HI: s_nxt.acc0[39:32] = w[7:0];
                `MAE_OFF_ACC1_LO: s_nxt.acc1[31:0]  = w;
                `MAE_OFF_ACC1_HI: s_nxt.acc1[39:32] = w[7:0];
                default: s_nxt.dreg[apb_req.paddr[4:2]] = w;
            endcase
        end
        // Execute the command one cycle after it was written. Sets come
        // last so an event beats a sticky clear in the same cycle.
        if (s_r.pend) begin
            if (s_r.cmd.run0) begin
                s_nxt.acc0   = u0.acc;
                s_nxt.st.av0 = u0.acc_sat;
                if (u0.acc_sat)
                    s_nxt.st.av0s = 1'b1;
                v_new = v_new | u0.res_sat;
                if (s_r.cmd.full)
                    s_nxt.dreg[{s_r.cmd.dest[2:1], 1'b0}] = u0.res;
                else
                    s_nxt.dreg[s_r.cmd.dest][15:0] = u0.res[15:0];
            end
            if (s_r.cmd.run1) begin
                s_nxt.acc1   = u1.acc;
                s_nxt.st.av1 = u1.acc_sat;
                if (u1.acc_sat)
                    s_nxt.st.second_accum_overflow_sticky = 1'b1;
                v_new = v_new | u1.res_sat;
                if (s_r.cmd.full)
                    s_nxt.dreg[{s_r.cmd.dest[2:1], 1'b1}] = u1.res;
                else
                    s_nxt.dreg[s_r.cmd.dest][31:16] = u1.res[15:0];
            end
            if (s_r.cmd.run0 || s_r.cmd.run1) begin
                s_nxt.st.v = v_new;
                if (v_new)
                    s_nxt.st.vs = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// ==== mae_mac_extract_sva.sv ====
// Checker for the multiply-accumulate block, watching its APB port.
// Assumes it is bound onto the top module and sees only its ports.
`timescale 1ns/100ps
`include "mae_defs.svh"

module mae_chk (
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // APB port
    input wire mae_pkg::mae_apb_req_s apb_req,
    input wire mae_pkg::mae_apb_rsp_s apb_rsp
);
    import mae_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus phases and address decode
    wire logic acc_ph = apb_req.psel && apb_req.penable;
    wire logic rd_ph  = acc_ph && !apb_req.pwrite;
    wire logic ctl_wr = acc_ph && apb_req.pwrite &&
                        apb_req.paddr == `MAE_OFF_CTRL;
    wire logic st_set = apb_req.psel && !apb_req.penable &&
                        !apb_req.pwrite && apb_req.paddr == `MAE_OFF_STAT;
    wire logic bad    = apb_req.paddr >= `MAE_OFF_END ||
                        apb_req.paddr[1:0] != 2'h0;
    wire logic hi_rd  = rd_ph && (apb_req.paddr == `MAE_OFF_ACC0_HI ||
                        apb_req.paddr == `MAE_OFF_ACC1_HI);

    ready_always_a: assert property (apb_rsp.pready)
        else $error("pready low");
    bad_addr_err_a: assert property (acc_ph && bad |-> apb_rsp.pslverr)
        else $error("no error on a bad address");
    good_addr_ok_a: assert property (acc_ph && !bad |-> !apb_rsp.pslverr)
        else $error("error on a good address");
    bad_read_zero_a: assert property (rd_ph && bad |-> apb_rsp.prdata == 0)
        else $error("bad read not zero");
    acc_hi_width_a: assert property (
        hi_rd |-> apb_rsp.prdata[31:8] == 24'h0)
        else $error("accumulator wider than 40 bits");
    stat_spare_a: assert property (
        rd_ph && apb_req.paddr == `MAE_OFF_STAT
        |-> apb_rsp.prdata[31:9] == 23'h0 && !apb_rsp.prdata[7])
        else $error("spare status bit set");
    busy_seen_a: assert property (
        ctl_wr ##1 st_set |=> apb_rsp.prdata[8])
        else $error("busy missing before execution");
    busy_gone_a: assert property (
        ctl_wr ##2 st_set |=> !apb_rsp.prdata[8])
        else $error("busy after execution");
    rdata_hold_a: assert property (
        !(apb_req.psel && !apb_req.penable) |=> $stable(apb_rsp.prdata))
        else $error("read data moved outside setup");

    // Main scenarios reached
    cover property (ctl_wr ##1 st_set);
    cover property (acc_ph && bad);
    cover property (hi_rd && apb_rsp.prdata[7:0] == 8'hff);
endmodule

bind mae_mac_extract mae_chk i_chk (
    .pclk    (pclk),
    .presetn (presetn),
    .apb_req (apb_req),
    .apb_rsp (apb_rsp)
);

// ==== mae_seq.sv ====
// Sequencer model: APB master that issues operands and commands.
// Assumes one clock shared with the datapath; callers enter at an edge.
`timescale 1ns/100ps

module mae_seq (
    // Clock
    input  wire logic            pclk,
    // APB master side
    output mae_pkg::mae_apb_req_s apb_req,
    input  wire mae_pkg::mae_apb_rsp_s apb_rsp
);
    import mae_pkg::*;
    logic held;

    // Bus idle at time zero
    initial begin
        apb_req = '0;
        held = 1'b0;
    end

    // Command word; full form only with its legal options
    function automatic logic [31:0] cmd(input logic [2:0] dest,
        input logic [1:0] fm, input logic [2:0] opt,
        input logic [1:0] op, input logic [1:0] run);
        mae_cmd_s c;
        c = {dest, fm, opt, op, run};
        if (c.full && !(c.opt inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6}))
            c.opt = 3'h0;
        return {20'h0, c};
    endfunction

    // One transfer; an idle cycle first unless the bus was held
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e,
        input logic rel);
        if (!held)
            @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1)
            @(posedge pclk);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        held = !rel;
        // Released lines invert so stale values never pass for live ones
        if (rel)
            apb_req <= '{1'b0, 1'b0, ~w, ~a, ~d};
    endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the multiply-accumulate and extract block.
// Assumes the checker is bound in and the sequencer model drives APB.
`timescale 1ns/100ps
`include "mae_defs.svh"

module tb;
    import mae_pkg::*;

    // Clock, reset, bus and tallies
    logic         pclk;
    logic         presetn;
    mae_apb_req_s apb_req;
    mae_apb_rsp_s apb_rsp;
    int           n_mismatch;
    int           compares;

    localparam logic [7:0] ad_ctl = `MAE_OFF_CTRL;
    localparam logic [7:0] ad_op0 = `MAE_OFF_OPS0;
    localparam logic [7:0] ad_op1 = `MAE_OFF_OPS1;
    localparam logic [7:0] ad_st  = `MAE_OFF_STAT;
    localparam logic [7:0] ad_a0l = `MAE_OFF_ACC0_LO;
    localparam logic [7:0] ad_a0h = `MAE_OFF_ACC0_HI;
    localparam logic [7:0] ad_a1l = `MAE_OFF_ACC1_LO;
    localparam logic [7:0] ad_a1h = `MAE_OFF_ACC1_HI;
    localparam logic [7:0] ad_dr  = `MAE_OFF_DREG;

    always #5 pclk = ~pclk;

    mae_mac_extract i_dut (
        .pclk    (pclk),
        .presetn (presetn),
        .apb_req (apb_req),
        .apb_rsp (apb_rsp)
    );
    mae_seq i_seq (
        .pclk    (pclk),
        .apb_req (apb_req),
        .apb_rsp (apb_rsp)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        i_seq.xfer(1'b1, a, d, q, e, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        i_seq.xfer(1'b0, a, 32'h0, q, e, 1'b1);
        chk(q, exp);
    endtask

    task automatic end_of_test();
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Truncating unsigned fraction: product, cut, clamp, stickies
    task automatic s_tfu();
        logic [31:0] q;
        logic        e;
        rd(ad_st, 32'h0);
        wr(ad_op0, 32'h8000_8000);
        i_seq.xfer(1'b1, ad_ctl, i_seq.cmd(3'h0, 2'h0, 3'h4, 2'h0, 2'h1),
                   q, e, 1'b0);
        rd(ad_st, 32'h0000_0100);
        rd(ad_dr, 32'h0000_4000);
        rd(ad_a0l, 32'h4000_0000);
        wr(ad_op0, 32'hffff_8000);
        wr(ad_ctl, i_seq.cmd(3'h0, 2'h0, 3'h4, 2'h0, 2'h1));
        rd(ad_dr, 32'h0000_7fff);
        wr(ad_a0l, 32'hffff_0000);
        wr(ad_a0h, 32'h0000_00ff);
        wr(ad_op0, 32'hffff_ffff);
        wr(ad_ctl, i_seq.cmd(3'h1, 2'h0, 3'h4, 2'h1, 2'h1));
        rd(ad_dr + 8'h04, 32'h0000_ffff);
        rd(ad_a0l, 32'hffff_ffff);
        rd(ad_a0h, 32'h0000_00ff);
        rd(ad_st, 32'h0000_001e);
        wr(ad_st, 32'h0000_0054);
        rd(ad_st, 32'h0000_000a);
    endtask

    // Scaled rounding on the second unit, then the rounding tie
    task automatic s_scaled_rounding_option();
        wr(ad_op1, 32'h8000_8000);
        wr(ad_ctl, i_seq.cmd(3'h2, 2'h0, 3'h5, 2'h0, 2'h2));
        rd(ad_dr + 8'h08, 32'h7fff_0000);
        rd(ad_a1l, 32'h7fff_ffff);
        rd(ad_st, 32'h0000_000e);
        for (int u = 0; u < 2; u++) begin
            wr(ad_st, 32'h0000_0054 | 32'(u));
            wr(ad_a0l, 32'h0000_4000);
            wr(ad_a0h, 32'h0);
            wr(ad_op0, 32'h0);
            wr(ad_ctl, i_seq.cmd(3'h4, 2'h0, 3'h5, 2'h1, 2'h1));
            rd(ad_dr + 8'h10, (u == 1) ? 32'h0 : 32'h1);
            rd(ad_a0l, 32'h0000_4000);
            rd(ad_st, 32'(u));
        end
    endtask

    // Scaled integer with subtract, then high-word integer
    task automatic s_int();
        wr(ad_st, 32'h0000_0054);
        wr(ad_a0l, 32'h0);
        wr(ad_op0, 32'h0005_0003);
        wr(ad_ctl, i_seq.cmd(3'h5, 2'h0, 3'h6, 2'h2, 2'h1));
        rd(ad_dr + 8'h14, 32'h0000_ffe2);
        rd(ad_a0h, 32'h0000_00ff);
        rd(ad_st, 32'h0);
        wr(ad_op0, 32'h0040_0100);
        wr(ad_ctl, i_seq.cmd(3'h5, 2'h0, 3'h6, 2'h0, 2'h1));
        rd(ad_dr + 8'h14, 32'h0000_7fff);
        wr(ad_a0l, 32'h7fff_0000);
        wr(ad_a0h, 32'h0);
        wr(ad_op0, 32'h7fff_7fff);
        wr(ad_ctl, i_seq.cmd(3'h6, 2'h0, 3'h7, 2'h1, 2'h1));
        rd(ad_dr + 8'h18, 32'h0000_7fff);
        rd(ad_a0l, 32'h7fff_ffff);
        rd(ad_st, 32'h0000_001e);
    endtask

    // Full-register form: pairing, mixed sign, fixed rounding
    task automatic s_full();
        wr(ad_st, 32'h0000_0055);
        wr(ad_op0, 32'h0003_0002);
        wr(ad_op1, 32'hffff_ffff);
        wr(ad_ctl, i_seq.cmd(3'h3, 2'h3, 3'h2, 2'h0, 2'h3));
        rd(ad_dr + 8'h08, 32'h0000_0006);
        rd(ad_dr + 8'h0c, 32'hffff_0001);
        rd(ad_a1h, 32'h0000_00ff);
        wr(ad_op0, 32'h0001_0001);
        wr(ad_ctl, i_seq.cmd(3'h0, 2'h2, 3'h5, 2'h0, 2'h1));
        // Status read straight after the command also sees busy drop
        rd(ad_st, 32'h0000_0001);
        rd(ad_dr, 32'h0000_0004);
        // Default fraction full form clamps an over-range sum
        wr(ad_op0, 32'h8000_8000);
        wr(ad_ctl, i_seq.cmd(3'h4, 2'h2, 3'h0, 2'h1, 2'h1));
        rd(ad_dr + 8'h10, 32'h7fff_ffff);
        rd(ad_a0l, 32'h8000_0001);
        rd(ad_st, 32'h0000_0007);
    endtask

    // Unmapped read and misaligned write are refused
    task automatic s_refuse();
        logic [31:0] q;
        logic        e;
        i_seq.xfer(1'b0, 8'h40, 32'h0, q, e, 1'b1);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        i_seq.xfer(1'b1, ad_dr + 8'h01, 32'hffff_ffff, q, e, 1'b1);
        chk({31'h0, e}, 32'h1);
        rd(ad_dr, 32'h0000_0004);
    endtask

    // Watchdog far beyond the expected run of a few hundred cycles
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end

    // Reset, then the scenarios in turn
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        n_mismatch = 0;
        compares = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_tfu();
        s_scaled_rounding_option();
        s_int();
        s_full();
        s_refuse();
        end_of_test();
    end
endmodule
